// >>> design/ohm_pkg.sv
// Constants for the overhead-bit and block-error monitor
package ohm_pkg;
  // Byte-one addresses with the read bit at zero
  localparam logic [7:0] A_OPR = 8'h20;
  localparam logic [7:0] A_CR2 = 8'h24;
  localparam logic [7:0] A_CR4 = 8'h28;
  localparam logic [7:0] A_CR6 = 8'h2C;
  localparam logic [7:0] A_RECEIVED_M4_BITS = 8'h30;
  localparam logic [7:0] A_TRANSMIT_M5_M6_BITS = 8'h32;
  localparam logic [7:0] A_RECEIVED_M5_M6_BITS = 8'h34;
  localparam logic [7:0] A_ACTIVATION_COMMAND = 8'h36;
  localparam logic [7:0] A_ACTIVATION_INDICATION = 8'h38;
  localparam logic [7:0] A_BLOCK_ERROR_COUNT_ONE = 8'h3A;
  localparam logic [7:0] A_BLOCK_ERROR_COUNT_TWO = 8'h3C;
  localparam logic [7:0] A_ERROR_THRESHOLD_ONE = 8'h3E;
  localparam logic [7:0] A_ERROR_THRESHOLD_TWO = 8'h40;
  localparam logic [7:0] A_READ_REQUEST_COMMAND = 8'h42;
  // Reset values
  localparam logic [7:0] R_RECEIVED_M4_BITS = 8'h75;
  localparam logic [7:0] R_M56 = 8'h1F;
  localparam logic [7:0] R_ACT = 8'h0F;
  localparam logic [7:0] R_ZERO = 8'h00;
  localparam logic [7:0] R_ECT = 8'hFF;
  localparam logic [7:0] R_CR6 = 8'h07;
  // Field positions
  localparam int B_CIE = 7;
  localparam int B_FIE = 5;
  localparam int B_OB0 = 3;
  localparam int B_C2E = 0;
  localparam int B_CID = 0;
  localparam int B_MOB = 1;
  localparam int B_TRANSMIT_ERROR_BIT_ENABLE = 2;
  localparam int B_RFS = 1;
  localparam int B_LFS = 0;
  localparam int B_RQM4 = 6;
  localparam int B_RQM56 = 5;
  localparam int B_RQACT = 4;
  localparam int B_RD = 0;
  // Spare bits of received M4: m43..m46 and m48
  localparam logic [7:0] M4_SPARE = 8'h3D;
  localparam logic [7:0] M56_SPARE = 8'h1C;
  localparam logic [1:0] FEB_ONES = 2'h3;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int STK_AW = 3;
  localparam int CRC_W = 12;
  // Stack request sources, one per pending flag
  typedef enum logic [2:0] {
    SRC_M4 = 3'h0,
    SRC_M56 = 3'h1,
    SRC_ACT = 3'h2,
    SRC_B1 = 3'h3,
    SRC_B2 = 3'h4,
    SRC_RB = 3'h5
  } ohm_src_type;
endpackage

// >>> design/ohm_monitor.sv
// Overhead-bit extraction, febe control, block error counters, stack
`timescale 1ns/10ps
module ohm_monitor
  import ohm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Host control port: byte one address, byte two data
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  // Interrupt stack head
  input wire logic stk_pop_i,
  output logic stk_valid_o,
  output logic [7:0] stk_addr_o,
  output logic [7:0] stk_data_o,
  // Line side
  input wire logic sf_sync_i,
  input wire logic sf_end_i,
  input wire logic tx_active_i,
  input wire logic [7:0] rx_m4_i,
  input wire logic [3:0] rx_m56_i,
  input wire logic [CRC_W-1:0] rx_crc_i,
  input wire logic [CRC_W-1:0] loc_crc_i,
  output logic [2:0] tx_m56_o,
  output logic tx_febe_o,
  // Activation sequencer
  input wire logic [3:0] act_ind_i,
  output logic [3:0] act_cmd_o,
  output logic [3:0] ind_code_o,
  output logic ind_ci_o,
  output logic ind_mon_o
);
  logic [7:0] opr_r, cr2_r, cr4_r, cr6_r;
  logic [7:0] received_m4_bits_r, received_m5_m6_bits_r, transmit_m5_m6_bits_r, activation_command_r, activation_indication_r;
  logic [7:0] block_error_count_one_r, block_error_count_two_r, error_threshold_one_r, error_threshold_two_r;
  logic [7:0] c4_r, c56_r;
  logic [1:0] n4_r, n56_r;
  logic crc_err_r, force_r;
  logic [5:0] pend_r;
  logic [15:0] mem [0:(1<<STK_AW)-1];
  logic [STK_AW-1:0] wp_r, rp_r;
  logic [STK_AW:0] cnt_r;
  logic stk_valid_r;
  logic [7:0] stk_addr_r, stk_data_r;
  logic [2:0] tx_m56_r;
  logic febe_r;
  logic [3:0] ind_r;
  logic ci_r, mon_r;
  logic [7:0] rb_addr_r;

  // Saturating step, shared by both counters
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic en);
    sat_inc = (en && v != CNT_MAX) ? v + 8'h01 : v;
  endfunction

  // Consecutive-equal count needed before a spare bit is believed
  function automatic logic [1:0] val_need(input logic [7:0] overhead_option_config);
    val_need = {1'b0, overhead_option_config[B_OB0]} + 2'h1;
  endfunction

  // Host decode
  wire wr = cmd_valid_i && !cmd_addr_i[B_RD];
  wire rd = cmd_valid_i && cmd_addr_i[B_RD];
  wire [7:0] ra = {cmd_addr_i[7:1], 1'b0};
  wire wr_opr = wr && ra == A_OPR;
  wire wr_cr2 = wr && ra == A_CR2;
  wire wr_cr4 = wr && ra == A_CR4;
  wire wr_cr6 = wr && ra == A_CR6;
  wire wr_tx56 = wr && ra == A_TRANSMIT_M5_M6_BITS;
  wire wr_activation_command = wr && ra == A_ACTIVATION_COMMAND;
  wire wr_error_threshold_one = wr && ra == A_ERROR_THRESHOLD_ONE;
  wire wr_error_threshold_two = wr && ra == A_ERROR_THRESHOLD_TWO;
  wire wr_read_request_command = wr && ra == A_READ_REQUEST_COMMAND;
  wire rd_known = ra == A_OPR || ra == A_CR2 || ra == A_CR4
    || ra == A_CR6 || ra == A_TRANSMIT_M5_M6_BITS || ra == A_ACTIVATION_COMMAND
    || ra == A_ERROR_THRESHOLD_ONE || ra == A_ERROR_THRESHOLD_TWO;

  // Frame events
  wire sf = sf_end_i && sf_sync_i;
  wire crc_err = sf && rx_crc_i != loc_crc_i;
  wire feb_err = sf && !rx_m56_i[0];
  wire mask = cr4_r[B_MOB];

  // Received M4: activation bits follow at once, spares must settle
  wire [7:0] m4_sp = rx_m4_i & M4_SPARE;
  wire m4_same = m4_sp == c4_r;
  wire [1:0] n4_nxt = m4_same ? (n4_r == 2'h3 ? n4_r : n4_r + 2'h1) : 2'h1;
  wire m4_val = sf && n4_nxt >= val_need(opr_r)
    && m4_sp != (received_m4_bits_r & M4_SPARE);
  wire [7:0] received_m4_bits_nxt = m4_val ? rx_m4_i
    : (received_m4_bits_r & M4_SPARE) | (rx_m4_i & ~M4_SPARE);

  // Received M5/M6: spare bits settle, febe and nebe follow each frame
  wire [7:0] m56_sp = {3'h0, rx_m56_i[3:1], 2'h0};
  wire m56_same = m56_sp == c56_r;
  wire [1:0] n56_nxt = m56_same ? (n56_r == 2'h3 ? n56_r : n56_r + 2'h1) : 2'h1;
  wire m56_val = sf && n56_nxt >= val_need(opr_r)
    && m56_sp != (received_m5_m6_bits_r & M56_SPARE);
  wire [7:0] sp56 = m56_val ? m56_sp : received_m5_m6_bits_r & M56_SPARE;
  wire [7:0] received_m5_m6_bits_nxt = {sp56[7:2], rx_m56_i[0], !crc_err};

  // Queue requests
  wire q_m4 = (m4_val && !mask) || (wr_read_request_command && cmd_data_i[B_RQM4]);
  wire q_m56 = (m56_val && !mask)
    || (feb_err && opr_r[B_FIE])
    || (crc_err && opr_r[B_CIE])
    || (wr_read_request_command && cmd_data_i[B_RQM56]);
  wire act_chg = act_ind_i != activation_indication_r[3:0];
  wire q_act = act_chg || (wr_read_request_command && cmd_data_i[B_RQACT]);

  // Counters: one per mode, two always far-end
  wire inc1 = crc_err || (opr_r[B_C2E] && feb_err);
  wire [7:0] b1_inc = sat_inc(block_error_count_one_r, inc1);
  wire [7:0] b2_inc = sat_inc(block_error_count_two_r, feb_err);
  wire q_b1 = inc1 && b1_inc != block_error_count_one_r && b1_inc == error_threshold_one_r;
  wire q_b2 = feb_err && !opr_r[B_C2E] && b2_inc != block_error_count_two_r && b2_inc == error_threshold_two_r;
  wire rd_b1 = rd && ra == A_BLOCK_ERROR_COUNT_ONE;
  wire rd_b2 = rd && ra == A_BLOCK_ERROR_COUNT_TWO;
  wire q_rb = rd && rd_known;

  // One entry a cycle, fixed priority; pending flags hold the rest
  wire [5:0] pend_set = {q_rb, q_b2, q_b1, q_act, q_m56, q_m4};
  wire [5:0] pend_all = pend_r | pend_set;
  wire full = cnt_r == (STK_AW+1)'(1 << STK_AW);
  wire [2:0] pick = pend_r[SRC_M4] ? SRC_M4 : pend_r[SRC_M56] ? SRC_M56
    : pend_r[SRC_ACT] ? SRC_ACT : pend_r[SRC_B1] ? SRC_B1
    : pend_r[SRC_B2] ? SRC_B2 : SRC_RB;
  wire enq = |pend_r && !full;
  wire [5:0] pend_clr = enq ? 6'(6'h01 << pick) : 6'h00;
  // Set wins over clear so no event slips through the grant cycle
  wire [5:0] pend_nxt = (pend_r & ~pend_clr) | pend_set;
  logic [15:0] ent;
  always_comb begin
    case (pick)
      SRC_M4: ent = {A_RECEIVED_M4_BITS, received_m4_bits_r};
      SRC_M56: ent = {A_RECEIVED_M5_M6_BITS, received_m5_m6_bits_r};
      SRC_ACT: ent = {A_ACTIVATION_INDICATION, activation_indication_r};
      SRC_B1: ent = {A_BLOCK_ERROR_COUNT_ONE, block_error_count_one_r};
      SRC_B2: ent = {A_BLOCK_ERROR_COUNT_TWO, block_error_count_two_r};
      default: ent = {rb_addr_r, rb_val(rb_addr_r)};
    endcase
  end

  // Read-back value of a host-written register
  function automatic logic [7:0] rb_val(input logic [7:0] a);
    if (a == A_OPR) rb_val = opr_r;
    else if (a == A_CR2) rb_val = cr2_r;
    else if (a == A_CR4) rb_val = cr4_r;
    else if (a == A_CR6) rb_val = cr6_r;
    else if (a == A_TRANSMIT_M5_M6_BITS) rb_val = transmit_m5_m6_bits_r;
    else if (a == A_ACTIVATION_COMMAND) rb_val = activation_command_r;
    else if (a == A_ERROR_THRESHOLD_ONE) rb_val = error_threshold_one_r;
    else rb_val = error_threshold_two_r;
  endfunction

  // Head stage feeds the ports straight from flops
  wire mem_ne = cnt_r != '0;
  wire load = mem_ne && (!stk_valid_r || stk_pop_i);
  wire [STK_AW:0] cnt_nxt = cnt_r + (STK_AW+1)'(enq) - (STK_AW+1)'(load);

  // Febe: force pending, local anomaly, permanent zero
  wire feb_wr0 = wr_tx56 && cr6_r[B_RFS] && cmd_data_i[1:0] != FEB_ONES;
  wire febe_nxt = cr6_r[B_TRANSMIT_ERROR_BIT_ENABLE]
    && !(force_r && cr6_r[B_RFS])
    && !(crc_err_r && !cr6_r[B_LFS]);
  wire tx_sf = sf_end_i && tx_active_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opr_r <= R_ZERO;
      cr2_r <= R_ZERO;
      cr4_r <= R_ZERO;
      cr6_r <= R_CR6;
      transmit_m5_m6_bits_r <= R_M56;
      activation_command_r <= R_ACT;
      error_threshold_one_r <= R_ECT;
      error_threshold_two_r <= R_ECT;
      rb_addr_r <= R_ZERO;
    end else begin
      if (wr_opr) opr_r <= cmd_data_i;
      if (wr_cr2) cr2_r <= cmd_data_i;
      if (wr_cr4) cr4_r <= cmd_data_i;
      if (wr_cr6) cr6_r <= cmd_data_i;
      // Force positions always read back as ones, from the write onward
      if (wr_tx56) transmit_m5_m6_bits_r <= {cmd_data_i[7:2], FEB_ONES};
      if (wr_activation_command) activation_command_r <= {4'h0, cmd_data_i[3:0]};
      if (wr_error_threshold_one) error_threshold_one_r <= cmd_data_i;
      if (wr_error_threshold_two) error_threshold_two_r <= cmd_data_i;
      if (q_rb) rb_addr_r <= ra;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      received_m4_bits_r <= R_RECEIVED_M4_BITS;
      received_m5_m6_bits_r <= R_M56;
      activation_indication_r <= R_ACT;
      c4_r <= R_ZERO;
      c56_r <= R_ZERO;
      n4_r <= 2'h0;
      n56_r <= 2'h0;
      crc_err_r <= 1'b0;
    end else begin
      activation_indication_r <= {4'h0, act_ind_i};
      if (sf) begin
        received_m4_bits_r <= received_m4_bits_nxt;
        received_m5_m6_bits_r <= received_m5_m6_bits_nxt;
        c4_r <= m4_sp;
        c56_r <= m56_sp;
        n4_r <= n4_nxt;
        n56_r <= n56_nxt;
        crc_err_r <= crc_err;
      end
    end
  end

  // Read-back clears the count; a same-cycle error is counted after
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block_error_count_one_r <= R_ZERO;
      block_error_count_two_r <= R_ZERO;
    end else begin
      block_error_count_one_r <= rd_b1 ? sat_inc(R_ZERO, inc1) : b1_inc;
      block_error_count_two_r <= rd_b2 ? sat_inc(R_ZERO, feb_err) : b2_inc;
    end
  end

  // Counter read answers through the stack with the value after clearing
  wire [5:0] pend_rd = {1'b0, rd_b2, rd_b1, 3'h0};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 6'h00;
    end else begin
      pend_r <= pend_nxt | pend_rd;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (enq) mem[wp_r] <= ent;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      stk_valid_r <= 1'b0;
      stk_addr_r <= R_ZERO;
      stk_data_r <= R_ZERO;
    end else begin
      if (enq) wp_r <= wp_r + STK_AW'(1);
      if (load) rp_r <= rp_r + STK_AW'(1);
      cnt_r <= cnt_nxt;
      if (load) begin
        stk_valid_r <= 1'b1;
        {stk_addr_r, stk_data_r} <= mem[rp_r];
      end else if (stk_pop_i) begin
        stk_valid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_m56_r <= 3'h7;
      febe_r <= 1'b1;
      force_r <= 1'b0;
      ind_r <= 4'hF;
      ci_r <= 1'b0;
      mon_r <= 1'b0;
    end else begin
      if (tx_sf) tx_m56_r <= transmit_m5_m6_bits_r[4:2];
      if (tx_sf) febe_r <= febe_nxt;
      // A new force write wins over the one being sent
      if (feb_wr0) force_r <= 1'b1;
      else if (tx_sf) force_r <= 1'b0;
      ci_r <= act_chg && !cr2_r[B_CID];
      mon_r <= act_chg && cr2_r[B_CID];
      if (act_chg) ind_r <= act_ind_i;
    end
  end

  assign stk_valid_o = stk_valid_r;
  assign stk_addr_o = stk_addr_r;
  assign stk_data_o = stk_data_r;
  assign tx_m56_o = tx_m56_r;
  assign tx_febe_o = febe_r;
  assign act_cmd_o = activation_command_r[3:0];
  assign ind_code_o = ind_r;
  assign ind_ci_o = ci_r;
  assign ind_mon_o = mon_r;

  // Checks
  a_febe_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_sf && !cr6_r[B_TRANSMIT_ERROR_BIT_ENABLE] |=> !tx_febe_o) else $error("febe not held low");
  a_febe_force: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_sf && force_r && cr6_r[B_RFS] |=> !tx_febe_o) else $error("forced febe missing");
  a_force_once: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_sf && !feb_wr0 |=> !force_r) else $error("force not released");
  a_crc_febe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_sf && crc_err_r && !cr6_r[B_LFS] |=> !tx_febe_o) else $error("crc error not reflected");
  a_act_noq: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    sf && !m4_val && !wr_read_request_command |-> !q_m4) else $error("activation bit queued");
  a_mask_m4: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    m4_val && !mask |=> pend_r[SRC_M4]) else $error("m4 entry lost");
  a_bec_sat: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    block_error_count_one_r == CNT_MAX && !rd_b1 |=> block_error_count_one_r == CNT_MAX) else $error("counter wrapped");
  a_bec_clr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_b2 && !feb_err |=> block_error_count_two_r == R_ZERO) else $error("counter not cleared");
  a_no_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cnt_r <= (STK_AW+1)'(1 << STK_AW)) else $error("stack overrun");
  a_crc_q: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    crc_err && opr_r[B_CIE] |=> pend_r[SRC_M56] && !received_m5_m6_bits_r[0]) else $error("crc entry");
  c_force: cover property (@(posedge sys_clk_i) feb_wr0 ##[1:20] tx_sf);
  c_full: cover property (@(posedge sys_clk_i) full && pend_r != 6'h00);
  c_thr: cover property (@(posedge sys_clk_i) q_b1);
endmodule

// >>> testbench/ohm_host.sv
// Host controller model: issues commands and pops the interrupt stack
`timescale 1ns/10ps
module ohm_host (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Stall control and stack head
  input wire logic stall_i,
  input wire logic stk_valid_i,
  input wire logic [7:0] stk_addr_i,
  input wire logic [7:0] stk_data_i,
  // Command port
  output logic cmd_valid_o,
  output logic [7:0] cmd_addr_o,
  output logic [7:0] cmd_data_o,
  output logic stk_pop_o,
  // Entries taken, one-cycle pulse
  output logic got_o,
  output logic [7:0] got_addr_o,
  output logic [7:0] got_data_o
);
  initial begin
    cmd_valid_o = 1'h0;
    cmd_addr_o = 8'h00;
    cmd_data_o = 8'h00;
  end
  // One strobe per command; read-request and threshold writes go through here
  task automatic send(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    cmd_addr_o = addr;
    cmd_data_o = data;
    cmd_valid_o = 1'h1;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'h0;
    // Released bytes show the inverse so a stale value is never mistaken for a command
    cmd_addr_o = ~addr;
    cmd_data_o = ~data;
  endtask
  // Pop only while a head is shown; stalling lets entries pile up
  always @(negedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stk_pop_o <= 1'h0;
    end else begin
      stk_pop_o <= stk_valid_i && !stall_i;
    end
  end
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      got_o <= 1'h0;
      got_addr_o <= 8'h00;
      got_data_o <= 8'h00;
    end else begin
      got_o <= stk_pop_o && stk_valid_i;
      got_addr_o <= stk_addr_i;
      got_data_o <= stk_data_i;
    end
  end
endmodule

// >>> testbench/ohm_monitor_tb.sv
// Self-checking testbench for the overhead-bit and block-error monitor
`timescale 1ns/10ps
module ohm_monitor_tb
  import ohm_pkg::*;
;
  logic sys_clk_i, rst_n_i, stall, sf_end, stk_valid, got, cmd_valid, stk_pop;
  logic [7:0] rx_m4, stk_addr, stk_data, got_addr, got_data, cmd_addr, cmd_data, v;
  logic [3:0] rx_m56, act_ind, act_cmd, ind_code;
  logic [CRC_W-1:0] rx_crc, loc_crc;
  logic [2:0] tx_m56;
  logic tx_febe, ind_ci, ind_mon, sync, txa;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  initial begin
    sys_clk_i = 1'h0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  ohm_monitor DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .stk_pop_i(stk_pop),
    .stk_valid_o(stk_valid), .stk_addr_o(stk_addr), .stk_data_o(stk_data),
    .sf_sync_i(sync), .sf_end_i(sf_end), .tx_active_i(txa), .rx_m4_i(rx_m4),
    .rx_m56_i(rx_m56), .rx_crc_i(rx_crc), .loc_crc_i(loc_crc), .tx_m56_o(tx_m56),
    .tx_febe_o(tx_febe), .act_ind_i(act_ind), .act_cmd_o(act_cmd),
    .ind_code_o(ind_code), .ind_ci_o(ind_ci), .ind_mon_o(ind_mon));
  ohm_host HOST (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .stall_i(stall),
    .stk_valid_i(stk_valid), .stk_addr_i(stk_addr), .stk_data_i(stk_data),
    .cmd_valid_o(cmd_valid), .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data),
    .stk_pop_o(stk_pop), .got_o(got), .got_addr_o(got_addr), .got_data_o(got_data));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    HOST.send(a, 8'h00);
  endtask
  // Read-request write: one forced entry expected
  task automatic req(input logic [7:0] d, input logic [15:0] e);
    exp_q.push_back(e);
    HOST.send(8'h42, d);
  endtask
  // Line inputs count only at the frame-end pulse, so the M4 and M5/M6 bits are scrambled in between
  task automatic frame(input logic [7:0] m4, input logic [3:0] m56, input logic err);
    @(negedge sys_clk_i);
    loc_crc = CRC_W'($urandom);
    rx_crc = loc_crc ^ {{(CRC_W-1){1'h0}}, err};
    rx_m4 = m4;
    rx_m56 = m56;
    sf_end = 1'h1;
    @(negedge sys_clk_i);
    sf_end = 1'h0;
    rx_m4 = ~m4;
    rx_m56 = ~m56;
  endtask
  task automatic drain();
    for (int i = 0; i < 200 && (exp_q.size() != 0 || stk_valid !== 1'h0); i++) begin
      @(negedge sys_clk_i);
    end
    repeat (6) @(negedge sys_clk_i);
    chk(16'(exp_q.size()), 16'h0000);
  endtask
  // Oldest note against each entry the host takes; a stray entry finds no note
  always @(posedge sys_clk_i) begin
    if (got === 1'h1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("mismatch at %0t: unexpected entry %h %h", $time, got_addr, got_data);
      end else begin
        chk({got_addr, got_data}, exp_q.pop_front());
      end
    end
  end
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
  initial begin
    rst_n_i = 1'h0;
    stall = 1'h0;
    sync = 1'h1;
    txa = 1'h1;
    sf_end = 1'h0;
    rx_m4 = 8'h75;
    rx_m56 = 4'hF;
    rx_crc = '0;
    loc_crc = '0;
    act_ind = 4'hF;
    v = 8'h00;
    void'($urandom(32'h78387B9F));
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    // Reset values queued in order while the host stalls
    stall = 1'h1;
    rd(8'h3F, 16'h3EFF);
    rd(8'h41, 16'h40FF);
    HOST.send(8'h10, 8'h55);
    HOST.send(8'h11, 8'h00);
    exp_q.push_back(16'h3075);
    exp_q.push_back(16'h341F);
    exp_q.push_back(16'h380F);
    HOST.send(8'h42, 8'h70);
    repeat (4) @(negedge sys_clk_i);
    HOST.send(8'h42, 8'h00);
    rd(8'h3F, 16'h3EFF);
    stall = 1'h0;
    drain();
    v = 8'($urandom);
    HOST.send(8'h3E, v);
    rd(8'h3F, {8'h3E, v});
    v = {4'h0, 4'($urandom)};
    HOST.send(8'h36, v);
    rd(8'h37, {8'h36, v});
    chk({12'h000, act_cmd}, {12'h000, v[3:0]});
    drain();
    // Counter one alarm at threshold, then clear on read
    HOST.send(8'h3E, 8'h03);
    frame(8'h75, 4'hF, 1'h1);
    frame(8'h75, 4'hF, 1'h1);
    exp_q.push_back(16'h3A03);
    frame(8'h75, 4'hF, 1'h1);
    drain();
    // A counter read queues the value as it stands after the clear
    rd(8'h3B, 16'h3A00);
    drain();
    rd(8'h3B, 16'h3A00);
    HOST.send(8'h3E, 8'hFF);
    // Counter two on received far errors
    HOST.send(8'h40, 8'h02);
    frame(8'h75, 4'hE, 1'h0);
    exp_q.push_back(16'h3C02);
    frame(8'h75, 4'hE, 1'h0);
    drain();
    rd(8'h3D, 16'h3C00);
    drain();
    rd(8'h3D, 16'h3C00);
    // Spares and a one-shot forced febe
    HOST.send(8'h32, 8'h0A);
    frame(8'h75, 4'hF, 1'h0);
    chk({13'h0000, tx_m56}, 16'h0002);
    chk({15'h0000, tx_febe}, 16'h0000);
    frame(8'h75, 4'hF, 1'h0);
    chk({15'h0000, tx_febe}, 16'h0001);
    rd(8'h33, 16'h320B);
    // Local CRC anomaly in and out of the febe
    HOST.send(8'h2C, 8'h06);
    frame(8'h75, 4'hF, 1'h1);
    frame(8'h75, 4'hF, 1'h1);
    chk({15'h0000, tx_febe}, 16'h0000);
    frame(8'h75, 4'hF, 1'h0);
    frame(8'h75, 4'hF, 1'h0);
    chk({15'h0000, tx_febe}, 16'h0001);
    HOST.send(8'h2C, 8'h07);
    frame(8'h75, 4'hF, 1'h1);
    frame(8'h75, 4'hF, 1'h1);
    chk({15'h0000, tx_febe}, 16'h0001);
    HOST.send(8'h2C, 8'h03);
    frame(8'h75, 4'hF, 1'h0);
    chk({15'h0000, tx_febe}, 16'h0000);
    // No transmit frame while the line is quiet, so febe holds
    txa = 1'h0;
    HOST.send(8'h2C, 8'h07);
    frame(8'h75, 4'hF, 1'h0);
    chk({15'h0000, tx_febe}, 16'h0000);
    txa = 1'h1;
    frame(8'h75, 4'hF, 1'h0);
    chk({15'h0000, tx_febe}, 16'h0001);
    drain();
    // CRC and febe interrupt enables
    HOST.send(8'h20, 8'h80);
    // Without superframe sync a CRC error is ignored
    sync = 1'h0;
    frame(8'h75, 4'hF, 1'h1);
    sync = 1'h1;
    exp_q.push_back(16'h341E);
    frame(8'h75, 4'hF, 1'h1);
    HOST.send(8'h20, 8'h20);
    exp_q.push_back(16'h341D);
    frame(8'h75, 4'hE, 1'h0);
    HOST.send(8'h20, 8'h00);
    drain();
    // Spare changes queue unless masked, activation bit changes do not
    exp_q.push_back(16'h3055);
    frame(8'h55, 4'hF, 1'h0);
    frame(8'hD7, 4'hF, 1'h0);
    req(8'h40, 16'h30D7);
    exp_q.push_back(16'h340F);
    frame(8'hD7, 4'h7, 1'h0);
    HOST.send(8'h28, 8'h02);
    frame(8'hD7, 4'hF, 1'h0);
    req(8'h20, 16'h341F);
    HOST.send(8'h28, 8'h00);
    drain();
    // Indication on both channels
    for (int i = 0; i < 2; i++) begin
      HOST.send(8'h24, 8'(i));
      // Always a real change of indication
      v = {4'h0, act_ind ^ 4'($urandom_range(1, 15))};
      exp_q.push_back({8'h38, v});
      @(negedge sys_clk_i);
      act_ind = v[3:0];
      for (int j = 0; j < 8 && (ind_ci | ind_mon) !== 1'h1; j++) begin
        @(negedge sys_clk_i);
      end
      chk({10'h000, ind_mon, ind_ci, ind_code}, {10'h000, i[0], !i[0], v[3:0]});
      drain();
    end
    complete_run();
  end
endmodule
